// file: shared/iap_consts.svh
// Constants for the interrupt acknowledge and priority block.
// Assumes inclusion by the package and by the design modules only.
`ifndef IAP_CONSTS_SVH
`define IAP_CONSTS_SVH

// Status word reset value and flag positions
`define IAP_STATUS_RST 8'h02
`define IAP_ENABLE_BIT 7
`define IAP_PRIO_BIT 1

// Software break vector (low byte address, high byte follows)
`define IAP_BREAK_VEC 16'h003e
`define IAP_BREAK_VEC_HI 16'h003f

// Default vectors for the watchdog and maskable sources
`define IAP_NMI_VEC_DEF 16'h0004
`define IAP_MVEC_BASE_DEF 16'h0006
`define IAP_VEC_SHIFT 1

// Source count limits and index width
`define IAP_NSRC_DEF 21
`define IAP_MAX_SRC 32
`define IAP_IDX_W 5

// Device share of service latency, in CPU clocks
`define IAP_HI_START_CYC 3
`define IAP_LO_START_CYC 4

`endif

// file: shared/iap_pkg.sv
// Types shared by the interrupt acknowledge and priority block.
// Assumes iap_consts.svh is on the include path.
`include "iap_consts.svh"

package iap_pkg;

	// Kind of instruction the sequencer reports at its boundary
	typedef enum logic [3:0] {
		iap_op_none,
		iap_op_status_read,
		iap_op_status_write,
		iap_op_status_bit,
		iap_op_int_enable,
		iap_op_int_disable,
		iap_op_sw_break,
		iap_op_ret_int,
		iap_op_ret_break,
		iap_op_push_status,
		iap_op_pop_status,
		iap_op_intctl_access
	} iap_op_type;

	// Instruction boundary report from the sequencer
	typedef struct packed {
		logic done;
		iap_op_type op;
		logic [7:0] data;
		logic [2:0] bit_sel;
		logic bit_val;
	} iap_instr_type;

	// Save and vector commands to the sequencer
	typedef struct packed {
		logic busy;
		logic stack_wr;
		logic stack_is_pc;
		logic [7:0] stack_status;
		logic vec_load;
		logic [15:0] vec_addr;
	} iap_save_type;

	// Save sequence states
	typedef enum logic [2:0] {
		iap_idle,
		iap_low_wait,
		iap_save_status,
		iap_save_pc,
		iap_load_vec
	} iap_seq_type;

	// Whole state of the controller
	typedef struct packed {
		iap_seq_type seq;
		logic [7:0] status;
		logic [7:0] saved;
		logic nmi_pend;
		logic nmi_act;
		logic [15:0] vec;
		logic [`IAP_MAX_SRC-1:0] ack;
	} iap_state_type;

endpackage

// file: hw/iap_prio_sel.sv
// Fixed default priority picker: lowest index among candidates wins.
// Assumes candidates are stable flags from the same clock domain.
`timescale 1ns/1ps
`include "iap_consts.svh"

module iap_prio_sel #(
	parameter int NSRC = `IAP_NSRC_DEF
) (
	input wire logic [NSRC-1:0] cand,
	output logic found,
	output logic [`IAP_IDX_W-1:0] idx
);

	// Index must fit the chosen width
	if (NSRC < 1 || NSRC > (1 << `IAP_IDX_W)) begin : g_bad_nsrc
		$error("iap_prio_sel: NSRC out of range");
	end

	// Scan from the lowest priority upward so index 0 ends on top
	always_comb begin
		found = 1'b0;
		idx = '0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (cand[i]) begin
				found = 1'b1;
				idx = `IAP_IDX_W'(i);
			end
		end
	end

endmodule

// file: hw/iap_core.sv
// Interrupt acknowledge and priority controller beside the CPU sequencer.
// Assumes the sequencer reports each instruction boundary, stalls while
// busy is high, pushes its own PC on the PC save cycle, and that request,
// mask and priority flags come from logic on ref_clk.
`timescale 1ns/1ps
`include "iap_consts.svh"

module iap_core #(
	parameter int NSRC = `IAP_NSRC_DEF,
	parameter logic [15:0] NMI_VEC = `IAP_NMI_VEC_DEF,
	parameter logic [15:0] MVEC_BASE = `IAP_MVEC_BASE_DEF
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire iap_pkg::iap_instr_type instr,
	input wire logic nmi_req,
	input wire logic [NSRC-1:0] request_flag,
	input wire logic [NSRC-1:0] mask_flag,
	input wire logic [NSRC-1:0] priority_flag,
	output logic [NSRC-1:0] ack_clear,
	output logic [7:0] program_status_word,
	output logic nmi_in_service,
	output iap_pkg::iap_save_type save
);

	// ------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------

	if (NSRC < 1 || NSRC > `IAP_MAX_SRC) begin : g_bad_nsrc
		$error("iap_core: NSRC out of range");
	end

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------

	iap_pkg::iap_state_type st_q;
	iap_pkg::iap_state_type st_d;
	logic [NSRC-1:0] cand;
	logic [NSRC-1:0] cand_hi;
	logic [NSRC-1:0] cand_lo;
	logic hi_found;
	logic lo_found;
	logic [`IAP_IDX_W-1:0] hi_idx;
	logic [`IAP_IDX_W-1:0] lo_idx;
	logic [`IAP_IDX_W-1:0] sel_idx;
	logic boundary;
	logic defer_op;
	logic can_take;
	logic start_brk;
	logic start_nmi;
	logic start_mask;
	logic ie_now;
	logic isp_now;

	// ------------------------------------------------------------
	// Request qualification
	// ------------------------------------------------------------

	// Requested and unmasked sources, split by programmable level
	assign cand = request_flag & ~mask_flag;
	assign cand_hi = cand & ~priority_flag;
	assign cand_lo = cand & priority_flag;

	// Default order within each level
	iap_prio_sel #(
		.NSRC(NSRC)
	) u_sel_hi (
		.cand(cand_hi),
		.found(hi_found),
		.idx(hi_idx)
	);

	iap_prio_sel #(
		.NSRC(NSRC)
	) u_sel_lo (
		.cand(cand_lo),
		.found(lo_found),
		.idx(lo_idx)
	);

	// High level beats low level, default order breaks ties
	assign sel_idx = hi_found ? hi_idx : lo_idx;

	assign ie_now = st_q.status[`IAP_ENABLE_BIT];
	assign isp_now = st_q.status[`IAP_PRIO_BIT];

	// ------------------------------------------------------------
	// Acceptance decision
	// ------------------------------------------------------------

	// Act only when an instruction has just finished
	assign boundary = instr.done && (st_q.seq == iap_pkg::iap_idle);

	// Instructions that hold requests back by one instruction
	always_comb begin
		case (instr.op)
			iap_pkg::iap_op_status_read,
			iap_pkg::iap_op_status_write,
			iap_pkg::iap_op_status_bit,
			iap_pkg::iap_op_int_enable,
			iap_pkg::iap_op_int_disable,
			iap_pkg::iap_op_ret_int,
			iap_pkg::iap_op_ret_break,
			iap_pkg::iap_op_push_status,
			iap_pkg::iap_op_pop_status,
			iap_pkg::iap_op_intctl_access: defer_op = 1'b1;
			default: defer_op = 1'b0;
		endcase
	end

	assign start_brk = boundary && (instr.op == iap_pkg::iap_op_sw_break);
	assign can_take = boundary && !defer_op && !start_brk;

	// Watchdog request ignores enable but never nests in itself
	assign start_nmi = can_take && st_q.nmi_pend && !st_q.nmi_act;

	// Maskable: enabled, and low level only outside a high routine
	assign start_mask = can_take && !start_nmi && !st_q.nmi_act && ie_now
		&& (hi_found || (lo_found && isp_now));

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------

	always_comb begin
		st_d = st_q;
		st_d.ack = '0;

		// One watchdog request is kept however many arrive
		st_d.nmi_pend = nmi_req || (st_q.nmi_pend && !start_nmi);

		// Status word effects of the finished instruction
		if (boundary) begin
			case (instr.op)
				iap_pkg::iap_op_status_write: st_d.status = instr.data;
				iap_pkg::iap_op_status_bit: st_d.status[instr.bit_sel] = instr.bit_val;
				iap_pkg::iap_op_int_enable: st_d.status[`IAP_ENABLE_BIT] = 1'b1;
				iap_pkg::iap_op_int_disable: st_d.status[`IAP_ENABLE_BIT] = 1'b0;
				iap_pkg::iap_op_ret_int: begin
					st_d.status = instr.data;
					st_d.nmi_act = 1'b0;
				end
				iap_pkg::iap_op_ret_break: st_d.status = instr.data;
				iap_pkg::iap_op_pop_status: st_d.status = instr.data;
				default: st_d.status = st_q.status;
			endcase
		end

		// Break always starts its own save
		if (start_brk) begin
			st_d.saved = st_q.status;
			st_d.status[`IAP_ENABLE_BIT] = 1'b0;
			st_d.vec = `IAP_BREAK_VEC;
			st_d.seq = iap_pkg::iap_save_status;
		end

		// Watchdog accept clears both flags
		if (start_nmi) begin
			st_d.saved = st_q.status;
			st_d.status[`IAP_ENABLE_BIT] = 1'b0;
			st_d.status[`IAP_PRIO_BIT] = 1'b0;
			st_d.nmi_act = 1'b1;
			st_d.vec = NMI_VEC;
			st_d.seq = iap_pkg::iap_save_status;
		end

		// Maskable accept copies the chosen source's level
		if (start_mask) begin
			st_d.saved = st_q.status;
			st_d.status[`IAP_ENABLE_BIT] = 1'b0;
			st_d.status[`IAP_PRIO_BIT] = !hi_found;
			st_d.vec = 16'(MVEC_BASE + (16'(sel_idx) << `IAP_VEC_SHIFT));
			st_d.ack[sel_idx] = 1'b1;
			st_d.seq = hi_found ? iap_pkg::iap_save_status : iap_pkg::iap_low_wait;
		end

		// Save sequence: status, then PC, then vector
		case (st_q.seq)
			iap_pkg::iap_idle: begin
			end
			iap_pkg::iap_low_wait: st_d.seq = iap_pkg::iap_save_status;
			iap_pkg::iap_save_status: st_d.seq = iap_pkg::iap_save_pc;
			iap_pkg::iap_save_pc: st_d.seq = iap_pkg::iap_load_vec;
			iap_pkg::iap_load_vec: st_d.seq = iap_pkg::iap_idle;
			default: st_d.seq = iap_pkg::iap_idle;
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q.seq <= iap_pkg::iap_idle;
			st_q.status <= `IAP_STATUS_RST;
			st_q.saved <= '0;
			st_q.nmi_pend <= 1'b0;
			st_q.nmi_act <= 1'b0;
			st_q.vec <= '0;
			st_q.ack <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------

	// Status word visible for reads and push instructions
	assign program_status_word = st_q.status;
	assign nmi_in_service = st_q.nmi_act;
	assign ack_clear = st_q.ack[NSRC-1:0];

	// Sequencer commands
	assign save.busy = (st_q.seq != iap_pkg::iap_idle);
	assign save.stack_wr = (st_q.seq == iap_pkg::iap_save_status) || (st_q.seq == iap_pkg::iap_save_pc);
	assign save.stack_is_pc = (st_q.seq == iap_pkg::iap_save_pc);
	assign save.stack_status = st_q.saved;
	assign save.vec_load = (st_q.seq == iap_pkg::iap_load_vec);
	assign save.vec_addr = st_q.vec;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	status_after_reset_a: assert property ($rose(rst_n) |-> st_q.status == `IAP_STATUS_RST)
		else $error("status word not at reset value");

	enable_instr_a: assert property (boundary && instr.op == iap_pkg::iap_op_int_enable
		|=> program_status_word[`IAP_ENABLE_BIT] && !save.busy)
		else $error("enable instruction did not set enable");

	save_clears_en_a: assert property (save.stack_wr && !save.stack_is_pc
		|-> !program_status_word[`IAP_ENABLE_BIT])
		else $error("enable still set while saving status");

	restore_status_a: assert property (boundary && instr.op == iap_pkg::iap_op_pop_status
		|=> program_status_word == $past(instr.data))
		else $error("pop did not restore status word");

	nmi_save_order_a: assert property (start_nmi |=> save.stack_wr && !save.stack_is_pc
		##1 save.stack_is_pc ##1 save.vec_load && save.vec_addr == NMI_VEC)
		else $error("watchdog save order wrong");

	nmi_flags_a: assert property (start_nmi |=> !program_status_word[`IAP_ENABLE_BIT]
		&& !program_status_word[`IAP_PRIO_BIT] && nmi_in_service)
		else $error("watchdog accept flags wrong");

	nmi_no_nest_a: assert property (nmi_in_service |-> !start_nmi && !start_mask)
		else $error("request nested in watchdog routine");

	mask_gate_a: assert property (start_mask |-> ie_now && (hi_found || isp_now) && |cand)
		else $error("maskable accepted against its conditions");

	low_latency_a: assert property (start_mask && !hi_found |-> ##4 save.vec_load)
		else $error("low level vector not after four clocks");

	high_latency_a: assert property (start_mask && hi_found |-> ##3 save.vec_load)
		else $error("high level vector not after three clocks");

	isp_copy_a: assert property (start_mask |=> program_status_word[`IAP_PRIO_BIT] == !$past(hi_found)
		&& ack_clear != '0)
		else $error("priority not copied on accept");

	break_vec_a: assert property (start_brk |-> ##3 save.vec_load && save.vec_addr == `IAP_BREAK_VEC)
		else $error("break vector wrong");

	defer_hold_a: assert property (instr.done && defer_op |-> !start_nmi && !start_mask)
		else $error("accept on deferring instruction");

	nmi_pend_keep_a: assert property (nmi_req |=> st_q.nmi_pend)
		else $error("watchdog request lost");

	nmi_single_a: assert property (start_nmi && !nmi_req |=> !st_q.nmi_pend)
		else $error("watchdog request counted twice");

	nmi_ignores_en_a: assert property (can_take && st_q.nmi_pend && !st_q.nmi_act && !ie_now
		|=> nmi_in_service && save.busy)
		else $error("watchdog refused while acceptance disabled");

	ret_clears_nmi_a: assert property (boundary && instr.op == iap_pkg::iap_op_ret_int
		|=> !nmi_in_service && !save.busy)
		else $error("accept on return or watchdog service kept");

	hi_beats_lo_a: assert property (start_mask && |(request_flag & ~mask_flag & ~priority_flag)
		|=> !program_status_word[`IAP_PRIO_BIT])
		else $error("low level taken over high level request");

	sel_valid_a: assert property (start_mask |-> request_flag[sel_idx] && !mask_flag[sel_idx])
		else $error("accepted source not requested or masked");

	low_refused_a: assert property (can_take && !hi_found && !isp_now |-> !start_mask)
		else $error("low level nested in high routine");

	mask_disabled_a: assert property (can_take && !ie_now |-> !start_mask)
		else $error("maskable accepted while acceptance disabled");

	nest_high_a: assert property (can_take && ie_now && !st_q.nmi_act && !st_q.nmi_pend && hi_found
		|-> start_mask)
		else $error("high level request not nested");

	break_prio_a: assert property (start_brk |=> save.busy && !program_status_word[`IAP_ENABLE_BIT]
		&& program_status_word[`IAP_PRIO_BIT] == $past(isp_now))
		else $error("break changed priority or kept enable");

	ack_onehot_a: assert property (ack_clear != '0 |-> $onehot(ack_clear))
		else $error("more than one request flag cleared");

	cover_nmi_c: cover property (start_nmi);
	cover_break_c: cover property (start_brk);
	cover_nest_hi_c: cover property (start_mask && !isp_now);
	cover_low_c: cover property (start_mask && !hi_found);

endmodule

// file: sim/iap_far_model.sv
// Far-side model: peripheral request flags and sequencer save capture.
// Assumes the controller's save outputs and ack_clear run on ref_clk.
`timescale 1ns/1ps

module iap_far_model #(
	parameter int NSRC = 21
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [NSRC-1:0] raise,
	input wire logic [NSRC-1:0] ack_clear,
	input wire iap_pkg::iap_instr_type instr,
	input wire iap_pkg::iap_save_type save,
	output logic [NSRC-1:0] request_flag,
	output logic [7:0] acc_cnt,
	output logic [15:0] last_vec,
	output logic [7:0] last_stk,
	output logic [3:0] last_lat
);
	logic [3:0] cyc_q;

	// Flags latch until acknowledged; stack and vector capture
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			request_flag <= '0;
			acc_cnt <= 8'h00;
			last_vec <= 16'h0000;
			last_stk <= 8'h00;
			last_lat <= 4'h0;
			cyc_q <= 4'h0;
		end else begin
			request_flag <= (request_flag | raise) & ~ack_clear;
			cyc_q <= instr.done ? 4'h0 : cyc_q + 4'h1;
			if (save.stack_wr && !save.stack_is_pc) begin
				last_stk <= save.stack_status;
			end
			if (save.vec_load) begin
				acc_cnt <= acc_cnt + 8'h01;
				last_vec <= save.vec_addr;
				last_lat <= cyc_q + 4'h1;
			end
		end
	end
endmodule

// file: sim/interrupt_acknowledge_priority_test.sv
// Self-checking bench for the acknowledge and priority controller.
// Assumes iap_pkg and the far-side model are compiled first.
`timescale 1ns/1ps

`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
	$display("unexpected at %0t ns: got %h expected %h", $time, got, exp); end end

module interrupt_acknowledge_priority_test;
	localparam int NSRC = 21;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	iap_pkg::iap_instr_type instr = '0;
	logic nmi_req = 1'b0;
	logic [NSRC-1:0] raise = '0;
	logic [NSRC-1:0] mask_flag = 21'h000200;
	logic [NSRC-1:0] priority_flag = 21'h000024;
	logic [NSRC-1:0] request_flag;
	logic [NSRC-1:0] ack_clear;
	logic [7:0] program_status_word;
	logic [7:0] acc_cnt;
	logic [7:0] last_stk;
	logic [7:0] base_cnt = 8'h00;
	logic [15:0] last_vec;
	logic [3:0] last_lat;
	logic nmi_in_service;
	iap_pkg::iap_save_type save;
	int mismatches = 0;
	int check_count = 0;

	// Clock
	always #5 ref_clk = ~ref_clk;

	iap_core #(.NSRC(NSRC)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .instr(instr), .nmi_req(nmi_req),
		.request_flag(request_flag), .mask_flag(mask_flag), .priority_flag(priority_flag),
		.ack_clear(ack_clear), .program_status_word(program_status_word),
		.nmi_in_service(nmi_in_service), .save(save));

	iap_far_model #(.NSRC(NSRC)) far_u (.ref_clk(ref_clk), .rst_n(rst_n), .raise(raise),
		.ack_clear(ack_clear), .instr(instr), .save(save), .request_flag(request_flag),
		.acc_cnt(acc_cnt), .last_vec(last_vec), .last_stk(last_stk), .last_lat(last_lat));

	// One boundary, then room for a whole save sequence
	task automatic step(input iap_pkg::iap_op_type op, input logic [7:0] data, input logic bv = 1'b0);
		int n = 0;
		while (save.busy !== 1'b0 && n < 20) begin
			@(negedge ref_clk);
			n++;
		end
		instr = '{done: 1'b1, op: op, data: data, bit_sel: 3'h7, bit_val: bv};
		@(negedge ref_clk);
		instr.done = 1'b0;
		repeat (6) @(negedge ref_clk);
	endtask

	// Exactly one accept since last check
	task automatic took(input logic [15:0] vec, input logic [7:0] stk, input logic [3:0] lat);
		`CHK(acc_cnt, base_cnt + 8'h01)
		`CHK(last_vec, vec)
		`CHK(last_stk, stk)
		`CHK(last_lat, lat)
		base_cnt = acc_cnt;
	endtask

	task automatic none_taken();
		`CHK(acc_cnt, base_cnt)
	endtask

	task automatic pulse(input logic [NSRC-1:0] src, input logic nmi);
		raise = src;
		nmi_req = nmi;
		@(negedge ref_clk);
		raise = '0;
		nmi_req = 1'b0;
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		#200000;
		mismatches++;
		stop_test();
	end

	// Main sequence
	initial begin
		repeat (5) @(negedge ref_clk);
		rst_n = 1'b1;
		@(negedge ref_clk);
		`CHK(program_status_word, 8'h02)
		`CHK(nmi_in_service, 1'b0)
		step(iap_pkg::iap_op_int_enable, 8'h00);
		`CHK(program_status_word, 8'h82)
		step(iap_pkg::iap_op_status_bit, 8'h00, 1'b0);
		`CHK(program_status_word, 8'h02)
		step(iap_pkg::iap_op_status_write, 8'hd5);
		step(iap_pkg::iap_op_int_disable, 8'h00);
		`CHK(program_status_word, 8'h55)
		step(iap_pkg::iap_op_pop_status, 8'h00);
		`CHK(program_status_word, 8'h00)
		$display("test status_access done");

		step(iap_pkg::iap_op_status_write, 8'h82);
		pulse(21'h0002a4, 1'b0);
		step(iap_pkg::iap_op_none, 8'h00);
		took(16'h0014, 8'h82, 4'h3);
		`CHK(program_status_word, 8'h00)
		step(iap_pkg::iap_op_int_enable, 8'h00);
		step(iap_pkg::iap_op_none, 8'h00);
		none_taken();
		step(iap_pkg::iap_op_ret_int, 8'h82);
		none_taken();
		step(iap_pkg::iap_op_none, 8'h00);
		took(16'h000a, 8'h82, 4'h4);
		`CHK(program_status_word, 8'h02)
		step(iap_pkg::iap_op_ret_int, 8'h82);
		step(iap_pkg::iap_op_none, 8'h00);
		took(16'h0010, 8'h82, 4'h4);
		step(iap_pkg::iap_op_ret_int, 8'h82);
		step(iap_pkg::iap_op_none, 8'h00);
		none_taken();
		mask_flag = '0;
		step(iap_pkg::iap_op_none, 8'h00);
		took(16'h0018, 8'h82, 4'h3);
		step(iap_pkg::iap_op_ret_int, 8'h00);
		$display("test maskable done");

		pulse('0, 1'b1);
		step(iap_pkg::iap_op_none, 8'h00);
		took(16'h0004, 8'h00, 4'h3);
		`CHK(nmi_in_service, 1'b1)
		step(iap_pkg::iap_op_int_enable, 8'h00);
		pulse(21'h000008, 1'b1);
		@(negedge ref_clk);
		pulse('0, 1'b1);
		step(iap_pkg::iap_op_none, 8'h00);
		none_taken();
		step(iap_pkg::iap_op_ret_int, 8'h80);
		none_taken();
		`CHK(nmi_in_service, 1'b0)
		step(iap_pkg::iap_op_none, 8'h00);
		took(16'h0004, 8'h80, 4'h3);
		`CHK(program_status_word, 8'h00)
		step(iap_pkg::iap_op_ret_int, 8'h80);
		step(iap_pkg::iap_op_none, 8'h00);
		took(16'h000c, 8'h80, 4'h3);
		step(iap_pkg::iap_op_ret_int, 8'h82);
		$display("test non_maskable done");

		step(iap_pkg::iap_op_sw_break, 8'h00);
		took(16'h003e, 8'h82, 4'h3);
		`CHK(program_status_word, 8'h02)
		step(iap_pkg::iap_op_ret_break, 8'h82);
		`CHK(program_status_word, 8'h82)
		pulse(21'h000010, 1'b0);
		step(iap_pkg::iap_op_intctl_access, 8'h00);
		none_taken();
		step(iap_pkg::iap_op_push_status, 8'h00);
		none_taken();
		`CHK(program_status_word, 8'h82)
		step(iap_pkg::iap_op_status_read, 8'h00);
		none_taken();
		step(iap_pkg::iap_op_none, 8'h00);
		took(16'h000e, 8'h82, 4'h3);
		$display("test break_defer done");
		stop_test();
	end
endmodule
